// >>> src/ppom_pkg.sv
// Summary of operation
// - pull-up override enable selects override value
// - otherwise pull-up when dir,out,pud = 010
// - direction override enable selects driver enable
// - otherwise driver enable follows direction bit
// - driven level is override value when enabled
// - otherwise driven level is output bit
// - toggle override inverts output bit
// - input enable override selects input enable
// - otherwise input enable follows sleep state
// - alternate input taken before port synchroniser
// - strobes per port, clock/sleep/pud global
// - timer1 b on bits 4/3, a on 1/0
// - direction one output, zero input
// - writing one to input bit toggles output
package ppom_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam int PPOM_NPINS = 6;
  localparam logic [31:0] PPOM_ADDR_DIR = 32'h0000_0000;
  localparam logic [31:0] PPOM_ADDR_OUT = 32'h0000_0004;
  localparam logic [31:0] PPOM_ADDR_PIN = 32'h0000_0008;
  localparam logic [31:0] PPOM_ADDR_CTRL = 32'h0000_000c;
  localparam logic [31:0] PPOM_ADDR_T1 = 32'h0000_0010;
  localparam int PPOM_CTRL_PUD = 0;
  localparam int PPOM_CTRL_SLEEP = 1;
  localparam int PPOM_T1_A_EN = 0;
  localparam int PPOM_T1_B_EN = 1;
  localparam logic [5:0] PPOM_RST_BITS = 6'h00;
  localparam int PPOM_PIN_T1B = 4;
  localparam int PPOM_PIN_T1BN = 3;
  localparam int PPOM_PIN_T1A = 1;
  localparam int PPOM_PIN_T1AN = 0;
  localparam logic [1:0] PPOM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] PPOM_HSIZE_WORD = 3'h2;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic [5:0] pullup_override_enable;
    logic [5:0] pullup_override_value;
    logic [5:0] direction_override_enable;
    logic [5:0] direction_override_value;
    logic [5:0] port_value_override_enable;
    logic [5:0] port_value_override_value;
    logic [5:0] port_toggle_override_enable;
    logic [5:0] input_enable_override_enable;
    logic [5:0] input_enable_override_value;
  } ppom_ovr_type;

  typedef struct packed {
    logic [5:0] pin_direction_bit;
    logic [5:0] pin_output_bit;
    logic global_pullup_disable;
    logic sleep_clamp;
    logic [1:0] t1_enable;
    logic ph_valid;
    logic ph_write;
    logic [2:0] ph_addr;
    logic [31:0] hrdata;
    logic [5:0] sync1;
    logic [5:0] pin_input_bit;
  } ppom_state_type;

endpackage : ppom_pkg

// >>> src/ppom_port.sv
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
module ppom_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire ppom_pkg::ppom_ovr_type ovr,
  input wire logic timer1_match_a_output,
  input wire logic timer1_match_b_output,
  input wire logic [5:0] pad_in,
  output logic [5:0] pad_out,
  output logic [5:0] pad_oe,
  output logic [5:0] pad_pullup,
  output logic [5:0] pad_input_enable,
  output logic [5:0] alt_raw_digital_input,
  output logic [5:0] alt_analog_pad
);
  import ppom_pkg::*;

  // ****************************************************
  // state
  // ****************************************************
  ppom_state_type s_q, s_d;
  ppom_ovr_type eff;
  logic wr_dir, wr_out, wr_pin, wr_ctrl, wr_t1;
  logic [5:0] toggle;

  function automatic logic [2:0] word_index(input logic [31:0] a);
    word_index = a[4:2];
  endfunction

  // ****************************************************
  // timer1 onto override lanes
  // ****************************************************
  always_comb begin
    eff = ovr;
    if (s_q.t1_enable[PPOM_T1_B_EN]) begin
      eff.port_value_override_enable[PPOM_PIN_T1B] = 1'b1;
      eff.port_value_override_value[PPOM_PIN_T1B] = timer1_match_b_output;
      eff.port_value_override_enable[PPOM_PIN_T1BN] = 1'b1;
      eff.port_value_override_value[PPOM_PIN_T1BN] = ~timer1_match_b_output;
    end
    if (s_q.t1_enable[PPOM_T1_A_EN]) begin
      eff.port_value_override_enable[PPOM_PIN_T1A] = 1'b1;
      eff.port_value_override_value[PPOM_PIN_T1A] = timer1_match_a_output;
      eff.port_value_override_enable[PPOM_PIN_T1AN] = 1'b1;
      eff.port_value_override_value[PPOM_PIN_T1AN] = ~timer1_match_a_output;
    end
  end

  // ****************************************************
  // pad control, combinational from state
  // ****************************************************
  always_comb begin
    for (int i = 0; i < PPOM_NPINS; i++) begin
      pad_pullup[i] = eff.pullup_override_enable[i] ? eff.pullup_override_value[i] :
        ({s_q.pin_direction_bit[i], s_q.pin_output_bit[i], s_q.global_pullup_disable}
         == 3'h2);
      pad_oe[i] = eff.direction_override_enable[i] ? eff.direction_override_value[i] :
        s_q.pin_direction_bit[i];
      pad_out[i] = eff.port_value_override_enable[i] ? eff.port_value_override_value[i] :
        s_q.pin_output_bit[i];
      pad_input_enable[i] = eff.input_enable_override_enable[i] ?
        eff.input_enable_override_value[i] : ~s_q.sleep_clamp;
    end
  end

  // raw input ahead of the port synchroniser; peripheral syncs it itself
  assign alt_raw_digital_input = pad_in & pad_input_enable;
  // analog path is the pad level itself, no gating
  assign alt_analog_pad = pad_in;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;

  // ****************************************************
  // bus decode, one port-wide strobe set
  // ****************************************************
  // shared port strobes
  assign wr_dir = s_q.ph_valid && s_q.ph_write && s_q.ph_addr == word_index(PPOM_ADDR_DIR);
  assign wr_out = s_q.ph_valid && s_q.ph_write && s_q.ph_addr == word_index(PPOM_ADDR_OUT);
  assign wr_pin = s_q.ph_valid && s_q.ph_write && s_q.ph_addr == word_index(PPOM_ADDR_PIN);
  assign wr_ctrl = s_q.ph_valid && s_q.ph_write && s_q.ph_addr == word_index(PPOM_ADDR_CTRL);
  assign wr_t1 = s_q.ph_valid && s_q.ph_write && s_q.ph_addr == word_index(PPOM_ADDR_T1);

  always_comb begin
    s_d = s_q;
    toggle = eff.port_toggle_override_enable | (wr_pin ? hwdata[5:0] : 6'h00);
    if (wr_dir) begin
      s_d.pin_direction_bit = hwdata[5:0];
    end
    if (wr_out) begin
      s_d.pin_output_bit = hwdata[5:0];
    end
    // toggle applies on top of a same-cycle write
    s_d.pin_output_bit = s_d.pin_output_bit ^ toggle;
    if (wr_ctrl) begin
      s_d.global_pullup_disable = hwdata[PPOM_CTRL_PUD];
      s_d.sleep_clamp = hwdata[PPOM_CTRL_SLEEP];
    end
    if (wr_t1) begin
      s_d.t1_enable = hwdata[1:0];
    end
    // pad synchroniser: sync1 feeds only pin_input_bit
    s_d.sync1 = pad_in & pad_input_enable;
    s_d.pin_input_bit = s_q.sync1;
    s_d.ph_valid = hsel && hready && htrans == PPOM_HTRANS_NONSEQ;
    s_d.ph_write = hwrite;
    s_d.ph_addr = word_index(haddr);
    s_d.hrdata = 32'h0000_0000;
    if (hsel && hready && htrans == PPOM_HTRANS_NONSEQ && !hwrite) begin
      case (word_index(haddr))
        word_index(PPOM_ADDR_DIR): s_d.hrdata = {26'h0, s_d.pin_direction_bit};
        word_index(PPOM_ADDR_OUT): s_d.hrdata = {26'h0, s_d.pin_output_bit};
        word_index(PPOM_ADDR_PIN): s_d.hrdata = {26'h0, s_q.pin_input_bit};
        word_index(PPOM_ADDR_CTRL): s_d.hrdata = {30'h0, s_d.sleep_clamp,
                                                 s_d.global_pullup_disable};
        word_index(PPOM_ADDR_T1): s_d.hrdata = {30'h0, s_d.t1_enable};
        default: s_d.hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pullup_override_a: assert property (
    ovr.pullup_override_enable[5] |-> pad_pullup[5] == ovr.pullup_override_value[5])
    else $error("pull-up override ignored");
  pullup_normal_a: assert property (
    !ovr.pullup_override_enable[5] |-> pad_pullup[5] ==
      (s_q.pin_direction_bit[5] == 1'b0 && s_q.pin_output_bit[5] && !s_q.global_pullup_disable))
    else $error("pull-up pattern wrong");
  dir_override_a: assert property (
    ovr.direction_override_enable[2] |-> pad_oe[2] == ovr.direction_override_value[2])
    else $error("direction override ignored");
  dir_normal_a: assert property (
    !ovr.direction_override_enable[2] |-> pad_oe[2] == s_q.pin_direction_bit[2])
    else $error("driver enable not from direction");
  value_override_a: assert property (
    ovr.port_value_override_enable[5] |-> pad_out[5] == ovr.port_value_override_value[5])
    else $error("value override ignored");
  value_normal_a: assert property (
    !ovr.port_value_override_enable[5] |-> pad_out[5] == s_q.pin_output_bit[5])
    else $error("driven level not output bit");
  toggle_override_a: assert property (
    ovr.port_toggle_override_enable[5] && !wr_out && !wr_pin |=>
      s_q.pin_output_bit[5] != $past(s_q.pin_output_bit[5]))
    else $error("toggle override lost");
  input_override_a: assert property (
    ovr.input_enable_override_enable[4] |->
      pad_input_enable[4] == ovr.input_enable_override_value[4])
    else $error("input enable override ignored");
  input_sleep_a: assert property (
    !ovr.input_enable_override_enable[4] |-> pad_input_enable[4] == !s_q.sleep_clamp)
    else $error("input enable not from sleep");
  pin_toggle_a: assert property (
    wr_pin && hwdata[2] && !ovr.port_toggle_override_enable[2] |=>
      s_q.pin_output_bit[2] != $past(s_q.pin_output_bit[2]))
    else $error("pin write did not toggle");
  sync_delay_a: assert property (
    ##2 pad_input_enable[0] && $past(pad_input_enable[0], 2) && $stable(pad_in[0]) |->
      s_q.pin_input_bit[0] == $past(pad_in[0], 2))
    else $error("synchroniser delay wrong");

  timer_b_map_a: assert property (
    s_q.t1_enable[PPOM_T1_B_EN] |-> pad_out[PPOM_PIN_T1B] == timer1_match_b_output &&
      pad_out[PPOM_PIN_T1BN] == !timer1_match_b_output)
    else $error("timer b mapping wrong");

  timer_a_map_a: assert property (
    s_q.t1_enable[PPOM_T1_A_EN] |-> pad_out[PPOM_PIN_T1A] == timer1_match_a_output &&
      pad_out[PPOM_PIN_T1AN] == !timer1_match_a_output)
    else $error("timer a mapping wrong");

  raw_input_a: assert property (
    alt_raw_digital_input == (pad_in & pad_input_enable))
    else $error("raw input not from pad");

  analog_pad_a: assert property (
    alt_analog_pad == pad_in)
    else $error("analog path not the pad");

  sync_stage_a: assert property (
    1'b1 |=> s_q.pin_input_bit == $past(s_q.sync1))
    else $error("second sync stage wrong");

  dir_write_a: assert property (
    wr_dir |=> s_q.pin_direction_bit == $past(hwdata[5:0]))
    else $error("direction write lost");

  out_write_a: assert property (
    wr_out && eff.port_toggle_override_enable == 6'h00 |=>
      s_q.pin_output_bit == $past(hwdata[5:0]))
    else $error("output write lost");

  dir_pin0_a: assert property (
    !ovr.direction_override_enable[0] |-> pad_oe[0] == s_q.pin_direction_bit[0])
    else $error("pin0 direction wrong");

  shared_pud_a: assert property (
    s_q.global_pullup_disable |->
      (pad_pullup & ~ovr.pullup_override_enable) == 6'h00)
    else $error("pull-up disable not global");

  shared_sleep_a: assert property (
    s_q.sleep_clamp |-> (pad_input_enable & ~ovr.input_enable_override_enable) == 6'h00)
    else $error("sleep clamp not global");

  ctrl_write_a: assert property (
    wr_ctrl |=> s_q.global_pullup_disable == $past(hwdata[PPOM_CTRL_PUD]) &&
      s_q.sleep_clamp == $past(hwdata[PPOM_CTRL_SLEEP]))
    else $error("ctrl write lost");

  // zero wait, always okay
  bus_okay_a: assert property (
    hreadyout && !hresp)
    else $error("bus response not okay");

  // read data only after a read
  read_idle_a: assert property (
    !(hsel && hready && htrans == PPOM_HTRANS_NONSEQ && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data not cleared");

  toggle_seen_c: cover property (wr_pin ##1 wr_pin);
  timer_b_c: cover property (s_q.t1_enable[PPOM_T1_B_EN] && pad_oe[PPOM_PIN_T1B]);
  pullup_on_c: cover property (pad_pullup[0] && !ovr.pullup_override_enable[0]);
  timer_a_c: cover property (s_q.t1_enable[PPOM_T1_A_EN] && pad_out[PPOM_PIN_T1AN]);
  toggle_ovr_c: cover property (ovr.port_toggle_override_enable[5]);

endmodule // ppom_port

// >>> testbench/ppom_periph_model.sv
`timescale 1ns/10ps
module ppom_periph_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire ppom_pkg::ppom_ovr_type req,
  input wire logic [1:0] t1_req,
  input wire logic [5:0] raw_in,
  output ppom_pkg::ppom_ovr_type ovr,
  output logic match_a,
  output logic match_b,
  output logic [5:0] raw_sync
);
  import ppom_pkg::*;
  logic [5:0] sync1_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovr <= '0;
      match_a <= 1'b0;
      match_b <= 1'b0;
    end else begin
      ovr <= req;
      match_a <= t1_req[0];
      match_b <= t1_req[1];
    end
  end
  // two flops, raw pin is async
  always_ff @(posedge clk) begin
    sync1_q <= raw_in;
    raw_sync <= sync1_q;
  end
endmodule // ppom_periph_model

// >>> testbench/tb_port_pin_override_mux.sv
`timescale 1ns/10ps
module tb_port_pin_override_mux;
  import ppom_pkg::*;
  logic clk, rst_n, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, t1_req;
  logic [2:0] hsize;
  logic [5:0] pad_in, pad_out, pad_oe, pad_pu, pad_ie, alt_raw, alt_ana, raw_sync;
  logic match_a, match_b, hreadyout;
  logic [15:0] r;
  ppom_ovr_type ovr_req, ovr, o;
  int failures, num_checks;
  // ****************************************************
  // rows: overrides, dir/out/pud/sleep, expected oe/out/pu/ie
  // ****************************************************
  logic [15:0] rows [13] = '{16'h0043, 16'h0061, 16'h00dc, 16'h0089, 16'hc0cf, 16'h8041,
    16'h3009, 16'h20c1, 16'h0c8d, 16'h08c9, 16'h0c43, 16'h0311, 16'h0200};
  assign hready = hreadyout;
  ppom_port u_ppom_port (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ovr(ovr),
    .timer1_match_a_output(match_a), .timer1_match_b_output(match_b), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pu), .pad_input_enable(pad_ie),
    .alt_raw_digital_input(alt_raw), .alt_analog_pad(alt_ana));
  ppom_periph_model u_ppom_periph_model (.clk(clk), .rst_n(rst_n), .req(ovr_req),
    .t1_req(t1_req), .raw_in(alt_raw), .ovr(ovr), .match_a(match_a), .match_b(match_b),
    .raw_sync(raw_sync));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single transfer; waits for hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= PPOM_HTRANS_NONSEQ;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // no test should need more than a few hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = PPOM_HSIZE_WORD;
    hwdata = 32'h0;
    ovr_req = '0;
    t1_req = 2'h0;
    pad_in = 6'h2d;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(pad_oe, 6'h00);
    chk(pad_pu, 6'h00);
    chk(pad_ie, 6'h3f);
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clk);
      ovr_req <= {{6{r[15]}}, {6{r[14]}}, {6{r[13]}}, {6{r[12]}}, {6{r[11]}}, {6{r[10]}},
        6'h00, {6{r[9]}}, {6{r[8]}}};
      bus(1'b1, PPOM_ADDR_DIR, {26'h0, {6{r[7]}}});
      bus(1'b1, PPOM_ADDR_OUT, {26'h0, {6{r[6]}}});
      bus(1'b1, PPOM_ADDR_CTRL, {30'h0, r[4], r[5]});
      @(negedge clk);
      chk(pad_oe, {6{r[3]}});
      if (r[3]) chk(pad_out, {6{r[2]}});
      chk(pad_pu, {6{r[1]}});
      chk(pad_ie, {6{r[0]}});
      chk(alt_raw, pad_in & {6{r[0]}});
    end
    @(posedge clk);
    ovr_req <= '0;
    bus(1'b1, PPOM_ADDR_DIR, 32'h3f);
    bus(1'b1, PPOM_ADDR_OUT, 32'h0);
    bus(1'b1, PPOM_ADDR_T1, 32'h3);
    for (int k = 1; k < 3; k++) begin
      @(posedge clk);
      t1_req <= k[1:0];
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(pad_out, (k == 1) ? 6'h0a : 6'h11);
    end
    bus(1'b1, PPOM_ADDR_T1, 32'h0);
    o = '0;
    o.direction_override_enable = 6'h20;
    o.direction_override_value = 6'h20;
    ovr_req <= o;
    bus(1'b1, PPOM_ADDR_DIR, 32'h0);
    bus(1'b1, PPOM_ADDR_OUT, 32'h3f);
    bus(1'b1, PPOM_ADDR_CTRL, 32'h1);
    @(negedge clk);
    chk(pad_oe, 6'h20);
    chk(pad_pu, 6'h00);
    chk(alt_ana, pad_in);
    o = '0;
    o.port_toggle_override_enable = 6'h24;
    bus(1'b1, PPOM_ADDR_OUT, 32'h0);
    @(posedge clk);
    ovr_req <= o;
    @(posedge clk);
    ovr_req <= '0;
    bus(1'b0, PPOM_ADDR_OUT, 32'h0);
    chk(rd[5:0], 6'h24);
    bus(1'b1, PPOM_ADDR_PIN, 32'h5);
    bus(1'b0, PPOM_ADDR_OUT, 32'h0);
    chk(rd[5:0], 6'h21);
    bus(1'b0, PPOM_ADDR_PIN, 32'h0);
    chk(rd[5:0], pad_in);
    bus(1'b1, 32'h14, 32'hffff_ffff);
    bus(1'b0, 32'h14, 32'h0);
    chk(rd[5:0], 6'h00);
    @(negedge clk);
    chk(raw_sync, alt_raw);
    print_verdict();
  end
endmodule // tb_port_pin_override_mux
